// file: pkg/mcu_exec_pkg.sv
package mcu_exec_pkg;

  // datapath widths
  localparam int DATA_W      = 8;
  localparam int PC_W        = 15;
  localparam int FADDR_W     = 7;
  localparam int LATCH_W     = 7;
  localparam int INSTR_W     = 14;
  localparam int STACK_DEPTH = 16;
  localparam int SPTR_W      = 4;
  localparam int SCNT_W      = 5;
  localparam int BUS_ADDR_W  = 6;
  localparam int BUS_DATA_W  = 32;
  localparam int WDT_PRE_W   = 8;
  localparam int WDT_CNT_W   = 8;

  // register byte offsets
  localparam logic [BUS_ADDR_W-1:0] OFS_STATUS    = 6'h00;
  localparam logic [BUS_ADDR_W-1:0] OFS_INSTR     = 6'h04;
  localparam logic [BUS_ADDR_W-1:0] OFS_ACC       = 6'h08;
  localparam logic [BUS_ADDR_W-1:0] OFS_PC        = 6'h0C;
  localparam logic [BUS_ADDR_W-1:0] OFS_PC_LATCH  = 6'h10;
  localparam logic [BUS_ADDR_W-1:0] OFS_WATCHDOG  = 6'h14;
  localparam logic [BUS_ADDR_W-1:0] OFS_FILE_ADDR = 6'h18;
  localparam logic [BUS_ADDR_W-1:0] OFS_FILE_DATA = 6'h1C;
  localparam logic [BUS_ADDR_W-1:0] OFS_STACK     = 6'h20;

  // status register bit positions
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_SKIP_BIT     = 1;
  localparam int ST_ZERO_BIT     = 2;
  localparam int ST_SLEEP_N_BIT  = 3;
  localparam int ST_EXPIRY_N_BIT = 4;
  localparam int ST_ILLEGAL_BIT  = 5;

  // read word field positions
  localparam int WDT_PRE_LSB     = 8;
  localparam int STACK_CNT_LSB   = 16;

  // whole-word opcodes
  localparam logic [INSTR_W-1:0] OPC_NOP            = 14'h0000;
  localparam logic [INSTR_W-1:0] OPC_CLEAR_WATCHDOG = 14'h0064;
  localparam logic [INSTR_W-1:0] OPC_INDIRECT_CALL  = 14'h000A;

  // opcode prefixes: bits 13:8 for file ops with destination, 13:7 otherwise
  localparam int PFX6_LSB = 8;
  localparam int PFX7_LSB = 7;
  localparam logic [5:0] PFX_INVERT   = 6'h09;
  localparam logic [5:0] PFX_DEC      = 6'h03;
  localparam logic [5:0] PFX_DEC_SKIP = 6'h0B;
  localparam logic [6:0] PFX_ZERO_REG = 7'h03;
  localparam logic [6:0] PFX_CLR_ACC  = 7'h02;
  localparam int DEST_BIT = 7;

  // reset and constant values
  localparam logic [DATA_W-1:0]     DATA_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0]     DATA_ONE   = 8'h01;
  localparam logic [PC_W-1:0]       PC_RESET   = 15'h0000;
  localparam logic [PC_W-1:0]       PC_ONE     = 15'h0001;
  localparam logic [LATCH_W-1:0]    LATCH_ZERO = 7'h00;
  localparam logic [FADDR_W-1:0]    FADDR_ZERO = 7'h00;
  localparam logic [WDT_PRE_W-1:0]  PRE_ZERO   = 8'h00;
  localparam logic [WDT_PRE_W-1:0]  PRE_ONE    = 8'h01;
  localparam logic [WDT_PRE_W-1:0]  PRE_LAST   = 8'hFF;
  localparam logic [WDT_CNT_W-1:0]  WDT_ZERO   = 8'h00;
  localparam logic [WDT_CNT_W-1:0]  WDT_ONE    = 8'h01;
  localparam logic [WDT_CNT_W-1:0]  WDT_LAST   = 8'hFF;
  localparam logic [BUS_DATA_W-1:0] WORD_ZERO  = 32'h0000_0000;
  localparam logic [3:0]            BE_FULL    = 4'hF;

  // execution sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_SECOND = 2'b10
  } exec_state_t;

endpackage

// file: rtl/mcu_exec_unit.sv
// Function
// - clear_watchdog_op loads the watchdog counter with zero.
// - clear_watchdog_op also zeroes prescaler and sets both active-low status flags.
// - indirect_call_op pushes the address of the following instruction first.
// - then PC low byte comes from accumulator, high bits from pc_upper_latch.
// - indirect_call_op takes two instruction cycles.
// - invert_register_op complements the file register into accumulator or file.
// - zero_register_op writes zero to the file register and sets zero flag.
// - clear_accumulator_op writes zero to the accumulator and sets zero flag.
// - decrement_register_op subtracts one, result to accumulator or file.
// - decrement_skip_op subtracts one, result to accumulator or file.
// - zero decrement_skip_op result discards next instruction as no_operation.
`timescale 1ns/1ps
module mcu_exec_unit (
  // clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  srst,
  // avalon-mm slave
  input  wire logic [mcu_exec_pkg::BUS_ADDR_W-1:0]   avs_address,
  input  wire logic                                  avs_read,
  input  wire logic                                  avs_write,
  input  wire logic [mcu_exec_pkg::BUS_DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                            avs_byteenable,
  output logic      [mcu_exec_pkg::BUS_DATA_W-1:0]   avs_readdata,
  output logic                                       avs_waitrequest
);
  import mcu_exec_pkg::*;

  // bus handshake
  logic                  waitrequest_reg;
  logic [BUS_DATA_W-1:0] readdata_reg;
  logic [BUS_DATA_W-1:0] rd_value;
  logic                  stall;
  logic                  accept;
  logic                  wr_fire;
  logic                  instr_fire;
  logic                  exec_fire;
  logic                  discard;

  // architectural state
  exec_state_t           state_reg;
  logic [DATA_W-1:0]     acc_reg;
  logic [PC_W-1:0]       pc_reg;
  logic [LATCH_W-1:0]    pc_upper_latch;
  logic                  zero_flag_reg;
  logic                  skip_reg;
  logic                  illegal_reg;
  logic                  sleep_flag_n;
  logic                  watchdog_expiry_flag_n;
  logic [WDT_PRE_W-1:0]  prescaler_reg;
  logic [WDT_CNT_W-1:0]  watchdog_counter;
  logic [INSTR_W-1:0]    last_instr_reg;
  logic [FADDR_W-1:0]    window_addr_reg;
  logic [DATA_W-1:0]     file_mem [2**FADDR_W];

  // decode
  logic [INSTR_W-1:0]    instr;
  logic [FADDR_W-1:0]    op_addr;
  logic                  dest_file;
  logic [DATA_W-1:0]     operand;
  logic [DATA_W-1:0]     result;
  logic                  result_zero;
  logic                  clear_watchdog_op;
  logic                  indirect_call_op;
  logic                  invert_register_op;
  logic                  zero_register_op;
  logic                  clear_accumulator_op;
  logic                  decrement_register_op;
  logic                  decrement_skip_op;
  logic                  no_operation;
  logic                  unknown_op;

  // stack view
  logic [PC_W-1:0]       stack_top;
  logic [SCNT_W-1:0]     stack_count;
  logic                  push_now;

  // a new instruction must wait while a two-cycle op finishes
  assign stall      = avs_write && (avs_address == OFS_INSTR) && (state_reg != ST_IDLE);
  assign accept     = (avs_read || avs_write) && waitrequest_reg && !stall;
  assign wr_fire    = accept && avs_write && (avs_byteenable == BE_FULL);
  assign instr_fire = wr_fire && (avs_address == OFS_INSTR);
  assign exec_fire  = instr_fire && !skip_reg;
  assign discard    = instr_fire && skip_reg;

  // instruction fields; the operand address is only seven bits wide
  assign instr     = avs_writedata[INSTR_W-1:0];
  assign op_addr   = instr[FADDR_W-1:0];
  assign dest_file = instr[DEST_BIT];
  assign operand   = file_mem[op_addr];

  // opcode decode, one flag per operation
  always_comb
  begin
    clear_watchdog_op     = (instr == OPC_CLEAR_WATCHDOG);
    indirect_call_op      = (instr == OPC_INDIRECT_CALL);
    no_operation          = (instr == OPC_NOP);
    invert_register_op    = (instr[INSTR_W-1:PFX6_LSB] == PFX_INVERT);
    decrement_register_op = (instr[INSTR_W-1:PFX6_LSB] == PFX_DEC);
    decrement_skip_op     = (instr[INSTR_W-1:PFX6_LSB] == PFX_DEC_SKIP);
    zero_register_op      = (instr[INSTR_W-1:PFX7_LSB] == PFX_ZERO_REG);
    clear_accumulator_op  = (instr[INSTR_W-1:PFX7_LSB] == PFX_CLR_ACC);
    unknown_op            = !(clear_watchdog_op || indirect_call_op || no_operation ||
                              invert_register_op || decrement_register_op ||
                              decrement_skip_op || zero_register_op ||
                              clear_accumulator_op);
  end

  // shared result path for complement and both decrements
  always_comb
  begin
    if (invert_register_op)
    begin
      result = ~operand;
    end
    else
    begin
      result = operand - DATA_ONE;
    end
    result_zero = (result == DATA_ZERO);
  end

  assign push_now = exec_fire && indirect_call_op;

  return_stack u_stack (
    .core_clk  (core_clk),
    .srst      (srst),
    .push      (push_now),
    .push_data (pc_reg + PC_ONE),
    .top_data  (stack_top),
    .depth     (stack_count)
  );

  // read mux; unmapped offsets read as zero
  always_comb
  begin
    rd_value = WORD_ZERO;
    case (avs_address)
      OFS_STATUS:
      begin
        rd_value[ST_BUSY_BIT]     = (state_reg != ST_IDLE);
        rd_value[ST_SKIP_BIT]     = skip_reg;
        rd_value[ST_ZERO_BIT]     = zero_flag_reg;
        rd_value[ST_SLEEP_N_BIT]  = sleep_flag_n;
        rd_value[ST_EXPIRY_N_BIT] = watchdog_expiry_flag_n;
        rd_value[ST_ILLEGAL_BIT]  = illegal_reg;
      end
      OFS_INSTR:     rd_value[INSTR_W-1:0] = last_instr_reg;
      OFS_ACC:       rd_value[DATA_W-1:0]  = acc_reg;
      OFS_PC:        rd_value[PC_W-1:0]    = pc_reg;
      OFS_PC_LATCH:  rd_value[LATCH_W-1:0] = pc_upper_latch;
      OFS_WATCHDOG:
      begin
        rd_value[WDT_CNT_W-1:0]                     = watchdog_counter;
        rd_value[WDT_PRE_LSB +: WDT_PRE_W]          = prescaler_reg;
      end
      OFS_FILE_ADDR: rd_value[FADDR_W-1:0] = window_addr_reg;
      OFS_FILE_DATA: rd_value[DATA_W-1:0]  = file_mem[window_addr_reg];
      OFS_STACK:
      begin
        rd_value[PC_W-1:0]                 = stack_top;
        rd_value[STACK_CNT_LSB +: SCNT_W]  = stack_count;
      end
      default:       rd_value = WORD_ZERO;
    endcase
  end

  // one-cycle answer: waitrequest drops for exactly one edge per access
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      waitrequest_reg <= 1'b1;
      readdata_reg    <= WORD_ZERO;
    end
    else
    begin
      waitrequest_reg <= !accept;
      if (accept && avs_read)
      begin
        readdata_reg <= rd_value;
      end
    end
  end

  assign avs_waitrequest = waitrequest_reg;
  assign avs_readdata    = readdata_reg;

  // sequencer: the call stays busy through its answer cycle and one more,
  // so an instruction written right behind it is held off for that cycle
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (push_now)
          begin
            state_reg <= ST_SECOND;
          end
        end
        ST_SECOND:
        begin
          if (waitrequest_reg)
          begin
            state_reg <= ST_IDLE;
          end
        end
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  // accumulator
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      acc_reg <= DATA_ZERO;
    end
    else if (wr_fire && avs_address == OFS_ACC)
    begin
      acc_reg <= avs_writedata[DATA_W-1:0];
    end
    else if (exec_fire)
    begin
      if (clear_accumulator_op)
      begin
        acc_reg <= DATA_ZERO;
      end
      else if ((invert_register_op || decrement_register_op || decrement_skip_op)
               && !dest_file)
      begin
        acc_reg <= result;
      end
    end
  end

  // data file: no reset, software initialises it through the window
  always_ff @(posedge core_clk)
  begin
    if (wr_fire && avs_address == OFS_FILE_DATA)
    begin
      file_mem[window_addr_reg] <= avs_writedata[DATA_W-1:0];
    end
    else if (exec_fire)
    begin
      if (zero_register_op)
      begin
        file_mem[op_addr] <= DATA_ZERO;
      end
      else if ((invert_register_op || decrement_register_op || decrement_skip_op)
               && dest_file)
      begin
        file_mem[op_addr] <= result;
      end
    end
  end

  // window pointer for software access to the data file
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      window_addr_reg <= FADDR_ZERO;
    end
    else if (wr_fire && avs_address == OFS_FILE_ADDR)
    begin
      window_addr_reg <= avs_writedata[FADDR_W-1:0];
    end
  end

  // program counter; a discarded instruction still advances it
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pc_reg <= PC_RESET;
    end
    else if (wr_fire && avs_address == OFS_PC)
    begin
      pc_reg <= avs_writedata[PC_W-1:0];
    end
    else if (push_now)
    begin
      pc_reg <= {pc_upper_latch, acc_reg};
    end
    else if (exec_fire || discard)
    begin
      pc_reg <= pc_reg + PC_ONE;
    end
  end

  // upper program-counter latch, software owned
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pc_upper_latch <= LATCH_ZERO;
    end
    else if (wr_fire && avs_address == OFS_PC_LATCH)
    begin
      pc_upper_latch <= avs_writedata[LATCH_W-1:0];
    end
  end

  // zero flag; call and decrement-skip leave it alone
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      zero_flag_reg <= 1'b0;
    end
    else if (exec_fire && (zero_register_op || clear_accumulator_op))
    begin
      zero_flag_reg <= 1'b1;
    end
    else if (exec_fire && (invert_register_op || decrement_register_op))
    begin
      zero_flag_reg <= result_zero;
    end
    else if (wr_fire && avs_address == OFS_STATUS)
    begin
      zero_flag_reg <= avs_writedata[ST_ZERO_BIT];
    end
  end

  // pending skip: the next instruction word is swallowed
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      skip_reg <= 1'b0;
    end
    else if (exec_fire && decrement_skip_op)
    begin
      skip_reg <= result_zero;
    end
    else if (discard)
    begin
      skip_reg <= 1'b0;
    end
  end

  // unknown opcode flag, write one to clear; a new set beats the clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      illegal_reg <= 1'b0;
    end
    else if (exec_fire && unknown_op)
    begin
      illegal_reg <= 1'b1;
    end
    else if (wr_fire && avs_address == OFS_STATUS && avs_writedata[ST_ILLEGAL_BIT])
    begin
      illegal_reg <= 1'b0;
    end
  end

  // remembered instruction word for readback, discarded ones included
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      last_instr_reg <= OPC_NOP;
    end
    else if (instr_fire)
    begin
      last_instr_reg <= instr;
    end
  end

  // watchdog prescaler and counter; the clear wins since it zeroes the count
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      prescaler_reg    <= PRE_ZERO;
      watchdog_counter <= WDT_ZERO;
    end
    else if (exec_fire && clear_watchdog_op)
    begin
      prescaler_reg    <= PRE_ZERO;
      watchdog_counter <= WDT_ZERO;
    end
    else
    begin
      prescaler_reg <= prescaler_reg + PRE_ONE;
      if (prescaler_reg == PRE_LAST)
      begin
        watchdog_counter <= watchdog_counter + WDT_ONE;
      end
    end
  end

  // expiry flag drops on counter wrap and stays low until cleared
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      watchdog_expiry_flag_n <= 1'b1;
    end
    else if (exec_fire && clear_watchdog_op)
    begin
      watchdog_expiry_flag_n <= 1'b1;
    end
    else if (prescaler_reg == PRE_LAST && watchdog_counter == WDT_LAST)
    begin
      watchdog_expiry_flag_n <= 1'b0;
    end
  end

  // sleep flag: software may drop it to model sleep entry elsewhere
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sleep_flag_n <= 1'b1;
    end
    else if (exec_fire && clear_watchdog_op)
    begin
      sleep_flag_n <= 1'b1;
    end
    else if (wr_fire && avs_address == OFS_STATUS)
    begin
      sleep_flag_n <= avs_writedata[ST_SLEEP_N_BIT];
    end
  end

endmodule

// file: rtl/return_stack.sv
`timescale 1ns/1ps
module return_stack (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  // push side
  input  wire logic                          push,
  input  wire logic [mcu_exec_pkg::PC_W-1:0] push_data,
  // view of the top
  output logic      [mcu_exec_pkg::PC_W-1:0] top_data,
  output logic      [mcu_exec_pkg::SCNT_W-1:0] depth
);
  import mcu_exec_pkg::*;

  logic [PC_W-1:0]   entry_mem [STACK_DEPTH];
  logic [SPTR_W-1:0] ptr_reg;
  logic [SCNT_W-1:0] depth_reg;
  logic [SPTR_W-1:0] top_idx;

  // circular store: a seventeenth push overwrites the oldest entry
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      entry_mem[ptr_reg] <= push_data;
    end
  end

  // pointer and fill count; count saturates at full depth
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ptr_reg   <= '0;
      depth_reg <= '0;
    end
    else if (push)
    begin
      ptr_reg <= ptr_reg + SPTR_W'(1);
      if (depth_reg != SCNT_W'(STACK_DEPTH))
      begin
        depth_reg <= depth_reg + SCNT_W'(1);
      end
    end
  end

  // empty stack shows zero rather than an unwritten entry
  assign top_idx  = ptr_reg - SPTR_W'(1);
  assign top_data = (depth_reg == '0) ? PC_RESET : entry_mem[top_idx];
  assign depth    = depth_reg;
endmodule

// file: tb/mcu_clear_call_decrement_ops_test.sv
`timescale 1ns/1ps
module mcu_clear_call_decrement_ops_test;
  import mcu_exec_pkg::*;
  // clock, reset and bus
  logic                  core_clk        = 1'b0;
  logic                  srst            = 1'b1;
  logic [BUS_ADDR_W-1:0] avs_address     = 6'h00;
  logic                  avs_read        = 1'b0;
  logic                  avs_write       = 1'b0;
  logic [BUS_DATA_W-1:0] avs_writedata   = WORD_ZERO;
  logic [3:0]            avs_byteenable  = BE_FULL;
  logic [BUS_DATA_W-1:0] avs_readdata;
  logic                  avs_waitrequest;
  logic [BUS_DATA_W-1:0] rd;
  int                    miscompares     = 0;
  int                    n_checks        = 0;
  int                    n_wait          = 0;

  mcu_exec_unit u_dut (
    .core_clk        (core_clk),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest)
  );

  // 200 MHz core clock
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // holds the request until waitrequest is sampled low, takes read data there
  task automatic wait_ack();
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      check("waitrequest", 32'h0000_0000, 32'h0000_0001);
    n_wait = n;
    rd = avs_readdata;
  endtask

  // one idle edge before each request, so no strobe is assigned twice in a step
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    wait_ack();
    avs_write     <= 1'b0;
    avs_read      <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
    xfer(1'b0, a, WORD_ZERO);
    check(what, exp, rd);
  endtask

  // zero flag write; sleep flag kept released
  task automatic set_z(input logic z);
    xfer(1'b1, OFS_STATUS, {27'h0000000, 1'b0, 1'b1, z, 2'b00});
  endtask

  task automatic t_watchdog();
    xfer(1'b1, OFS_STATUS, WORD_ZERO);
    repeat (300) @(posedge core_clk);
    xfer(1'b0, OFS_WATCHDOG, WORD_ZERO);
    check("watchdog running", 32'h1, {31'h0, rd[7:0] != WDT_ZERO});
    xfer(1'b1, OFS_INSTR, {18'h00000, OPC_CLEAR_WATCHDOG});
    rd_chk("status after clear", OFS_STATUS, 32'h0000_0018);
    xfer(1'b1, OFS_INSTR, {18'h00000, OPC_CLEAR_WATCHDOG});
    xfer(1'b0, OFS_WATCHDOG, WORD_ZERO);
    check("watchdog counter", 32'h0, {24'h000000, rd[7:0]});
    check("prescaler cleared", 32'h1, {31'h0, rd[15:8] < 8'h08});
  endtask

  // call then a no-op held back to back on the bus
  task automatic t_call();
    xfer(1'b1, OFS_ACC, 32'h0000_00A5);
    xfer(1'b1, OFS_PC_LATCH, 32'h0000_005A);
    xfer(1'b1, OFS_PC, 32'h0000_1234);
    set_z(1'b1);
    xfer(1'b1, OFS_INSTR, {18'h00000, OPC_INDIRECT_CALL});
    rd_chk("pc after call", OFS_PC, 32'h0000_5AA5);
    rd_chk("stack top", OFS_STACK, 32'h0001_1235);
    rd_chk("status after call", OFS_STATUS, 32'h0000_001C);
    @(posedge core_clk);
    avs_address   <= OFS_INSTR;
    avs_writedata <= {18'h00000, OPC_INDIRECT_CALL};
    avs_write     <= 1'b1;
    wait_ack();
    avs_writedata <= {18'h00000, OPC_NOP};
    wait_ack();
    avs_write     <= 1'b0;
    check("edges to no-op answer", 32'h0000_0003, n_wait);
    rd_chk("pc after call and no-op", OFS_PC, 32'h0000_5AA6);
    rd_chk("stack after second call", OFS_STACK, 32'h0002_5AA6);
  endtask

  // one file-register instruction, destination and flags checked
  task automatic t_file(input logic [6:0] hi, input logic [6:0] a, input logic [7:0] init,
                        input logic [7:0] res, input logic to_file, input logic z_pre,
                        input logic z_exp);
    logic skip;
    skip = hi[6:1] == PFX_DEC_SKIP && res == DATA_ZERO;
    xfer(1'b1, OFS_FILE_ADDR, {25'h0000000, a});
    xfer(1'b1, OFS_FILE_DATA, {24'h000000, init});
    xfer(1'b1, OFS_ACC, 32'h0000_003C);
    set_z(z_pre);
    xfer(1'b1, OFS_INSTR, {18'h00000, hi, a});
    rd_chk("status after op", OFS_STATUS, {27'h0000000, 2'b11, z_exp, skip, 1'b0});
    rd_chk("result", to_file ? OFS_FILE_DATA : OFS_ACC, {24'h000000, res});
    if (hi[6:1] == PFX_DEC_SKIP)
    begin
      xfer(1'b1, OFS_INSTR, {18'h00000, PFX_CLR_ACC, 7'h00});
      rd_chk("acc after next", OFS_ACC, {24'h000000, skip ? 8'h3C : DATA_ZERO});
    end
  endtask

  // unknown word only advances the pc and raises the sticky flag
  task automatic t_illegal();
    set_z(1'b0);
    xfer(1'b1, OFS_INSTR, 32'h0000_3FFF);
    rd_chk("illegal flag", OFS_STATUS, 32'h0000_0038);
    xfer(1'b1, OFS_STATUS, 32'h0000_0028);
    rd_chk("illegal cleared", OFS_STATUS, 32'h0000_0018);
  endtask

  // reset, then scenarios in order
  initial
  begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    t_watchdog();
    t_call();
    t_file({PFX_INVERT, 1'b0}, 7'h7F, 8'hFF, 8'h00, 1'b0, 1'b0, 1'b1);
    t_file({PFX_INVERT, 1'b1}, 7'h05, 8'h5A, 8'hA5, 1'b1, 1'b1, 1'b0);
    t_file({PFX_DEC, 1'b0}, 7'h10, 8'h01, 8'h00, 1'b0, 1'b0, 1'b1);
    t_file({PFX_DEC, 1'b1}, 7'h11, 8'h00, 8'hFF, 1'b1, 1'b1, 1'b0);
    t_file({PFX_DEC_SKIP, 1'b1}, 7'h12, 8'h01, 8'h00, 1'b1, 1'b0, 1'b0);
    t_file({PFX_DEC_SKIP, 1'b0}, 7'h13, 8'h05, 8'h04, 1'b0, 1'b1, 1'b1);
    t_file(PFX_ZERO_REG, 7'h14, 8'h77, 8'h00, 1'b1, 1'b0, 1'b1);
    t_file(PFX_CLR_ACC, 7'h00, 8'h77, 8'h00, 1'b0, 1'b0, 1'b1);
    t_illegal();
    rd_chk("unmapped read", 6'h3C, WORD_ZERO);
    summarize();
  end

  // hang guard, far beyond the fewer than 600 cycles the run needs
  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
endmodule

// file: tb/mcu_exec_checker.sv
`timescale 1ns/1ps
module mcu_exec_checker (
  // clock and reset
  input wire logic                                core_clk,
  input wire logic                                srst,
  // avalon-mm slave side
  input wire logic [mcu_exec_pkg::BUS_ADDR_W-1:0] avs_address,
  input wire logic                                avs_read,
  input wire logic                                avs_write,
  input wire logic [mcu_exec_pkg::BUS_DATA_W-1:0] avs_writedata,
  input wire logic [3:0]                          avs_byteenable,
  input wire logic [mcu_exec_pkg::BUS_DATA_W-1:0] avs_readdata,
  input wire logic                                avs_waitrequest
);
  import mcu_exec_pkg::*;
  logic        ins_ack;
  logic [13:0] ins_op;
  // instruction write at its handshake edge; assumes no skip pending then
  assign ins_ack = avs_write && !avs_waitrequest && avs_address == OFS_INSTR;
  assign ins_op  = avs_writedata[13:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for two cycles");
  a_idle_wait_high: assert property (!avs_read && !avs_write && avs_waitrequest
    |=> avs_waitrequest) else $error("answer without a request");
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest
    && avs_address != OFS_INSTR |=> !avs_waitrequest) else $error("late answer");
  a_instr_bounded: assert property (avs_write && avs_waitrequest && avs_address == OFS_INSTR
    |-> ##[1:2] !avs_waitrequest) else $error("instruction write stalled too long");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > OFS_STACK
    |=> avs_readdata == WORD_ZERO) else $error("unmapped read not zero");
  a_wdt_cleared: assert property (ins_ack && ins_op == OPC_CLEAR_WATCHDOG
    ##2 (avs_read && avs_address == OFS_WATCHDOG)
    |=> avs_readdata[7:0] == WDT_ZERO && avs_readdata[15:8] < 8'h08)
    else $error("watchdog not cleared");
  a_flags_set: assert property (ins_ack && ins_op == OPC_CLEAR_WATCHDOG
    ##2 (avs_read && avs_address == OFS_STATUS)
    |=> avs_readdata[ST_SLEEP_N_BIT] && avs_readdata[ST_EXPIRY_N_BIT])
    else $error("watchdog status flags not set");
  a_clr_acc_zero: assert property (ins_ack && ins_op[13:7] == PFX_CLR_ACC
    ##2 (avs_read && avs_address == OFS_STATUS) |=> avs_readdata[ST_ZERO_BIT])
    else $error("zero flag not set by accumulator clear");
  a_zero_reg_flag: assert property (ins_ack && ins_op[13:7] == PFX_ZERO_REG
    ##2 (avs_read && avs_address == OFS_STATUS) |=> avs_readdata[ST_ZERO_BIT])
    else $error("zero flag not set by register clear");
endmodule

bind mcu_exec_unit mcu_exec_checker u_checker (
  .core_clk        (core_clk),
  .srst            (srst),
  .avs_address     (avs_address),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_writedata   (avs_writedata),
  .avs_byteenable  (avs_byteenable),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest)
);
